// *** slc_pkg.sv ***
// Constants, field layout and register map of the static LCD output block
// Function
// R1 - duty_bias_sel picks quarter, third, half duty or static drive
// R2 - In static drive only backplane_drive is common; dual outputs become segments
// R3 - seg28_enable low holds last_segment_out low, high drives segment 28
// R4 - In static drive data bits 5 to 28 drive same-index segment outputs
// R5 - Fixed-level ports take their level from display data bits 1 to 4
// R6 - port_pin_split read in order makes first N shared pins ports
// R7 - port1_func_sel picks fixed level, clock output or PWM
// R8 - port1_func_sel both ones routes PWM channel 1 to port 1
// R9 - Ports 2 to 4 choose fixed level or PWM only, no clock
// R10 - Port 2 selector first 1 second 0 routes PWM channel 1
// R11 - Port 3 selector first 0 second 1 routes PWM channel 2
// R12 - Port 4 selector both ones routes PWM channel 3
// R13 - Selector 00 gives fixed level, low when its data bit is 0
// R14 - Three independent PWM channels, each with its own 6-bit width
// R15 - Channel 2 width 0,1,0,0,1,1 gives 79.69 percent high
// R16 - Width all ones gives 100 percent, five ones then zero 50 percent
// R17 - pwm_rate_sel 0,1,0,0 gives 234.37 Hz PWM frequency
// R18 - frame_rate_sel 0,1,0,1 gives 97.66 Hz frame frequency
// R19 - Both clock selects zero runs from the internal oscillator
// R20 - blank_all_segments turns all segments off, keeping other settings
// R21 - Host drives display_blank_n low before power down; display forced off
// R22 - Host opens every transfer with device address 44h and full set; the AXI4-Lite host here sends no device address
// R23 - low_power_select stops clocks, holds LCD outputs low, still accepts data
// R24 - Display data bit 1 turns its segment on, 0 leaves it off
// R25 - Host waits over 1 ms after power-on before the first transfer
// R26 - Host releases display_blank_n over 10 us after initial transfer
// R27 - PWM on-fraction is width plus one over 64, bit 0 least significant
// R28 - New fields apply together at the end of a complete transfer
package slc_pkg;
    localparam longint CLK_HZ = 20_000_000;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_DISP   = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_WIDTH  = 8'h08;
    localparam logic [7:0] ADDR_COMMIT = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] WIDTH_RESET = 32'h0000_0000;
    // Control and width word field positions
    localparam int F_DUTY = 0, F_SPLIT = 2, F_SEG28 = 5, F_EXT = 6, F_OSCP = 7;
    localparam int F_BLANK = 8, F_LOWP = 9, F_PS1 = 10, F_PS2 = 12, F_PS3 = 14;
    localparam int F_PS4 = 16, F_PRATE = 18, F_FRATE = 22;
    localparam int F_W1 = 0, F_W2 = 8, F_W3 = 16;
    // Display data bit index of D(n) is n-1
    localparam int DISP_BITS = 28, N_PORTS = 4, SEG_LO = 4, N_SEG = 20;
    localparam int IDX_S25 = 24, IDX_S26 = 25, IDX_S27 = 26, IDX_S28 = 27;
    localparam logic [1:0] DUTY_QUARTER = 2'h0, DUTY_THIRD = 2'h1;
    localparam logic [1:0] DUTY_HALF = 2'h2, DUTY_STATIC = 2'h3;
    localparam logic [1:0] FUNC_LEVEL = 2'h0, FUNC_CH1 = 2'h1;
    localparam logic [1:0] FUNC_CH2 = 2'h2, FUNC_CH3 = 2'h3;
    localparam logic [1:0] P1_CLOCK = 2'h2, P1_CH1 = 2'h3;
    localparam logic [5:0] PWM_MAX = 6'h3f;
    // Rates: reference codes and their printed frequencies in 0.01 Hz
    localparam longint PWM_HZ_X100 = 23437, PWM_REF_CODE = 2, PWM_STEPS = 64;
    localparam longint FRAME_HZ_X100 = 9766, FRAME_REF_CODE = 10;
    localparam longint PWM_ACC_LIMIT = CLK_HZ * (PWM_REF_CODE + 1) * 100
                                       / (PWM_HZ_X100 * PWM_STEPS);
    // Two phase ticks per frame
    localparam longint FRAME_ACC_DEF = CLK_HZ * (FRAME_REF_CODE + 1) * 100
                                       / (FRAME_HZ_X100 * 2);
endpackage : slc_pkg

// *** slc_lcd_ctrl.sv ***
// Static LCD driver output configuration with AXI4-Lite register access
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module slc_lcd_ctrl #(
    parameter int FRAME_ACC_LIMIT = int'(slc_pkg::FRAME_ACC_DEF)
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [slc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [slc_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    input  wire logic                       ext_clk_in,
    input  wire logic                       display_blank_n,
    output logic                            backplane_drive,
    output logic                            dual_out_27,
    output logic                            dual_out_26,
    output logic                            dual_out_25,
    output logic [slc_pkg::N_SEG-1:0]       seg_out,
    output logic                            last_segment_out,
    output logic [slc_pkg::N_PORTS-1:0]     shared_out
);
    import slc_pkg::*;

    localparam int FW = $clog2(FRAME_ACC_LIMIT + 16) + 1;
    localparam int PW = $clog2(int'(PWM_ACC_LIMIT) + 16) + 1;
    localparam int B_MIN = 1;
    localparam int B_MAX = 2;

    // ==========================================================
    // Register bus
    logic [ADDR_W-1:0]    aw_addr_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 do_write;
    logic [DISP_BITS-1:0] disp_stage;
    logic [DISP_BITS-1:0] disp_live;
    logic [31:0]          ctrl_stage;
    logic [31:0]          ctrl_live;
    logic [31:0]          width_stage;
    logic [31:0]          width_live;
    logic                 pending;
    logic                 phase;
    logic                 ext_rise;
    logic                 inh_sync;
    logic [31:0]          disp_merged;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Display word is padded to a full bus word before the byte merge
    assign disp_merged = merge({4'h0, disp_stage}, w_data_q, w_strb_q);

    assign do_write = !awready && !wready && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (awvalid && awready) begin
                awready   <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready   <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp  <= (aw_addr_q <= ADDR_COMMIT && aw_addr_q[1:0] == 2'h0)
                          ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Staged fields become live only on commit, never piecemeal
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disp_stage  <= '0;
            ctrl_stage  <= CTRL_RESET;
            width_stage <= WIDTH_RESET;
            disp_live   <= '0;
            ctrl_live   <= CTRL_RESET;
            width_live  <= WIDTH_RESET;
            pending     <= 1'b0;
        end else if (do_write) begin
            unique case (aw_addr_q)
                ADDR_DISP: begin
                    disp_stage <= disp_merged[DISP_BITS-1:0];
                    pending    <= 1'b1;
                end
                ADDR_CTRL: begin
                    ctrl_stage <= merge(ctrl_stage, w_data_q, w_strb_q);
                    pending    <= 1'b1;
                end
                ADDR_WIDTH: begin
                    width_stage <= merge(width_stage, w_data_q, w_strb_q);
                    pending     <= 1'b1;
                end
                ADDR_COMMIT: begin
                    if (w_strb_q[0] && w_data_q[0]) begin // R28
                        disp_live  <= disp_stage;
                        ctrl_live  <= ctrl_stage;
                        width_live <= width_stage;
                        pending    <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= RESP_OKAY;
            unique case (araddr)
                ADDR_DISP:   rdata <= {4'h0, disp_stage};
                ADDR_CTRL:   rdata <= ctrl_stage;
                ADDR_WIDTH:  rdata <= width_stage;
                ADDR_COMMIT: rdata <= '0;
                ADDR_STATUS: rdata <= {28'h0, !inh_sync, ext_rise, phase, pending};
                default: begin
                    rdata <= '0;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ==========================================================
    // Pin synchronisers
    logic ext_meta, ext_sync, ext_prev, inh_meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
            inh_meta <= 1'b0;
            inh_sync <= 1'b0;
        end else begin
            ext_meta <= ext_clk_in;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            inh_meta <= display_blank_n;
            inh_sync <= inh_meta;
        end
    end
    assign ext_rise = ext_sync && !ext_prev;

    // ==========================================================
    // Time base
    logic       low_pwr;
    logic       base_en;
    logic [4:0] pwm_inc, frame_inc;
    logic [PW-1:0] pwm_acc, pwm_sum;
    logic [FW-1:0] frame_acc, frame_sum;
    logic       pwm_tick, frame_tick;

    assign low_pwr = ctrl_live[F_LOWP];
    // Internal oscillator unless the external clock is chosen; halted in low power
    assign base_en = !low_pwr && (ctrl_live[F_EXT] ? ext_rise : 1'b1); // R19 R23
    // Rate codes scale linearly around the documented reference codes
    assign pwm_inc   = {1'b0, ctrl_live[F_PRATE +: 4]} + 5'h01;
    assign frame_inc = {1'b0, ctrl_live[F_FRATE +: 4]} + 5'h01;
    assign pwm_sum   = pwm_acc + PW'(pwm_inc);
    assign frame_sum = frame_acc + FW'(frame_inc);
    assign pwm_tick   = base_en && pwm_sum >= PW'(PWM_ACC_LIMIT);
    assign frame_tick = base_en && frame_sum >= FW'(FRAME_ACC_LIMIT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_acc <= '0;
        end else if (pwm_tick) begin
            pwm_acc <= pwm_sum - PW'(PWM_ACC_LIMIT); // R17
        end else if (base_en) begin
            pwm_acc <= pwm_sum;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_acc <= '0;
        end else if (frame_tick) begin
            frame_acc <= frame_sum - FW'(FRAME_ACC_LIMIT); // R18
        end else if (base_en) begin
            frame_acc <= frame_sum;
        end
    end

    // ==========================================================
    // PWM channels and clock output
    logic [5:0] pwm_step;
    logic [2:0] pwm_on;
    logic       clk_tgl;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_step <= '0;
            clk_tgl  <= 1'b0;
        end else if (pwm_tick) begin
            pwm_step <= pwm_step + 6'h01;
            clk_tgl  <= !clk_tgl;
        end
    end

    // Width w is high for steps 0..w, so (w+1)/64 on-time
    assign pwm_on[0] = pwm_step <= width_live[F_W1 +: 6]; // R14 R16 R27
    assign pwm_on[1] = pwm_step <= width_live[F_W2 +: 6]; // R15
    assign pwm_on[2] = pwm_step <= width_live[F_W3 +: 6];

    // ==========================================================
    // Frame phase and common slot
    logic [1:0] slot;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 1'b0;
            slot  <= '0;
        end else if (frame_tick) begin
            phase <= !phase;
            if (phase) begin
                unique case (ctrl_live[F_DUTY +: 2])
                    DUTY_QUARTER: slot <= slot + 2'h1;
                    DUTY_THIRD:   slot <= (slot == 2'h2) ? 2'h0 : slot + 2'h1;
                    DUTY_HALF:    slot <= (slot == 2'h1) ? 2'h0 : 2'h1;
                    DUTY_STATIC:  slot <= 2'h0;
                endcase
            end
        end
    end

    // ==========================================================
    // Output pins
    logic [1:0] duty;
    logic [2:0] split_n;
    logic [2:0] gp_count;
    logic       lcd_off;
    logic [1:0] psel [N_PORTS];

    assign duty    = ctrl_live[F_DUTY +: 2];
    // Split read P0 first as the high bit
    assign split_n = {ctrl_live[F_SPLIT], ctrl_live[F_SPLIT+1], ctrl_live[F_SPLIT+2]};
    assign gp_count = (split_n <= 3'(N_PORTS)) ? split_n : 3'h0; // R6
    assign lcd_off  = !inh_sync || low_pwr; // R21 R23
    assign psel[0] = ctrl_live[F_PS1 +: 2];
    assign psel[1] = ctrl_live[F_PS2 +: 2];
    assign psel[2] = ctrl_live[F_PS3 +: 2];
    assign psel[3] = ctrl_live[F_PS4 +: 2];

    // Segment level: opposite of common phase when lit
    function automatic logic seg_lvl(input logic d, input logic blank,
                                     input logic ph);
        return ph ^ (d && !blank); // R20 R24
    endfunction : seg_lvl

    function automatic logic com_lvl(input logic [1:0] s, input logic [1:0] k,
                                     input logic ph);
        return (s == k) ? ph : 1'b0;
    endfunction : com_lvl

    always_ff @(posedge aclk) begin
        if (!aresetn || !inh_sync) begin
            backplane_drive  <= 1'b0;
            dual_out_27      <= 1'b0;
            dual_out_26      <= 1'b0;
            dual_out_25      <= 1'b0;
            seg_out          <= '0;
            last_segment_out <= 1'b0;
        end else if (low_pwr) begin
            backplane_drive  <= 1'b0; // R23
            dual_out_27      <= 1'b0;
            dual_out_26      <= 1'b0;
            dual_out_25      <= 1'b0;
            seg_out          <= '0;
            last_segment_out <= 1'b0;
        end else begin
            backplane_drive <= com_lvl(slot, 2'h0, phase); // R1
            for (int i = 0; i < N_SEG; i++) begin
                seg_out[i] <= seg_lvl(disp_live[SEG_LO+i], ctrl_live[F_BLANK], phase); // R4
            end
            dual_out_27 <= (duty == DUTY_STATIC)
                ? seg_lvl(disp_live[IDX_S27], ctrl_live[F_BLANK], phase) // R2
                : com_lvl(slot, 2'h1, phase);
            dual_out_26 <= (duty == DUTY_STATIC || duty == DUTY_HALF)
                ? seg_lvl(disp_live[IDX_S26], ctrl_live[F_BLANK], phase)
                : com_lvl(slot, 2'h2, phase);
            dual_out_25 <= (duty != DUTY_QUARTER)
                ? seg_lvl(disp_live[IDX_S25], ctrl_live[F_BLANK], phase)
                : com_lvl(slot, 2'h3, phase);
            last_segment_out <= ctrl_live[F_SEG28] // R3
                ? seg_lvl(disp_live[IDX_S28], ctrl_live[F_BLANK], phase) : 1'b0;
        end
    end

    // Shared pins: segment or general-purpose port
    always_ff @(posedge aclk) begin
        if (!aresetn || !inh_sync) begin
            shared_out <= '0;
        end else begin
            for (int i = 0; i < N_PORTS; i++) begin
                if (3'(i) >= gp_count) begin
                    shared_out[i] <= low_pwr ? 1'b0
                        : seg_lvl(disp_live[i], ctrl_live[F_BLANK], phase);
                end else if (low_pwr || psel[i] == FUNC_LEVEL) begin
                    shared_out[i] <= disp_live[i]; // R5 R13
                end else if (i == 0) begin
                    unique case (psel[0]) // R7
                        P1_CH1:   shared_out[0] <= pwm_on[0]; // R8
                        P1_CLOCK: shared_out[0] <= clk_tgl;
                        default:  shared_out[0] <= disp_live[0];
                    endcase
                end else begin
                    unique case (psel[i]) // R9
                        FUNC_CH1: shared_out[i] <= pwm_on[0]; // R10
                        FUNC_CH2: shared_out[i] <= pwm_on[1]; // R11
                        default:  shared_out[i] <= pwm_on[2]; // R12
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Checks
    logic [6:0] on_cnt;
    logic [5:0] w2_prev;
    logic       w2_stable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_cnt    <= '0;
            w2_prev   <= '0;
            w2_stable <= 1'b0;
        end else if (pwm_tick) begin
            w2_prev <= width_live[F_W2 +: 6];
            if (pwm_step == PWM_MAX) begin
                on_cnt    <= '0;
                w2_stable <= 1'b1;
            end else begin
                on_cnt    <= on_cnt + 7'(pwm_on[1]);
                w2_stable <= w2_stable && (w2_prev == width_live[F_W2 +: 6]);
            end
        end
    end

    a_pwm_fraction: assert property (@(posedge aclk) disable iff (!aresetn) // R27
        (pwm_tick && pwm_step == PWM_MAX && w2_stable
         && w2_prev == width_live[F_W2 +: 6])
        |-> (on_cnt + 7'(pwm_on[1])) == 7'(width_live[F_W2 +: 6]) + 7'h01)
        else $error("PWM on-count does not match width plus one");

    a_inhibit_off: assert property (@(posedge aclk) disable iff (!aresetn) // R21
        !inh_sync |=> (seg_out == '0 && !backplane_drive && shared_out == '0))
        else $error("Outputs not forced off while inhibited");

    a_lowpwr_low: assert property (@(posedge aclk) disable iff (!aresetn) // R23
        low_pwr |=> (seg_out == '0 && !backplane_drive && !dual_out_25))
        else $error("LCD outputs not low in power saving");

    a_seg28_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        !ctrl_live[F_SEG28] |=> !last_segment_out)
        else $error("Last segment driven while disabled");

    a_port4_ch3: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        (!lcd_off && gp_count == 3'h4 && psel[3] == FUNC_CH3)
        |=> shared_out[3] == $past(pwm_on[2]))
        else $error("Port 4 not following PWM channel 3");

    a_port2_ch1: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        (!lcd_off && gp_count >= 3'h2 && psel[1] == FUNC_CH1)
        |=> shared_out[1] == $past(pwm_on[0]))
        else $error("Port 2 not following PWM channel 1");

    a_level_port: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        (inh_sync && gp_count != 3'h0 && psel[0] == FUNC_LEVEL)
        |=> shared_out[0] == $past(disp_live[0]))
        else $error("Fixed-level port 1 not following data bit");

    a_static_dual: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        (!lcd_off && duty == DUTY_STATIC && !ctrl_live[F_BLANK])
        |=> dual_out_27 == ($past(phase) ^ $past(disp_live[IDX_S27])))
        else $error("Dual output 27 not acting as segment in static drive");

    a_commit_atomic: assert property (@(posedge aclk) disable iff (!aresetn) // R28
        !(do_write && aw_addr_q == ADDR_COMMIT)
        |=> ($stable(ctrl_live) && $stable(disp_live) && $stable(width_live)))
        else $error("Live fields changed without a commit");

    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        (awvalid && awready && wvalid && wready) |-> ##[B_MIN:B_MAX] bvalid)
        else $error("Write response missing");
endmodule : slc_lcd_ctrl

// *** slc_host_model.sv ***
// Host model of the inhibit pin
`timescale 1ns/1ps
module slc_host_model (
    input  wire logic display_on,
    output logic      display_blank_n = 1'b0
);
    // Release waits out the setting time
    always @(display_on) begin
        if (display_on) #10110 display_blank_n = display_on;
        else display_blank_n = 1'b0;
    end
endmodule : slc_host_model

// *** testbench.sv ***
// LCD output block testbench
`timescale 1ns/1ps
module testbench;
    import slc_pkg::*;
    // ==========
    // Signals
    localparam logic [31:0] CA = 32'h02bc_0027;
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0;
    logic rready = '0, on = '0, awready, wready, bvalid, arready, rvalid, blank_n;
    logic bp, d27, d26, d25, s28, ext_clk = '0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp, bq[$];
    logic [3:0] sh;
    logic [19:0] seg;
    logic [27:0] dd;
    logic [33:0] rq[$];
    int fails = 0, cmp_count = 0, cyc = 0, cnt[4] = '{0, 0, 0, 0}, pe[4] = '{32, 32, 51, 64};
    int tb, ts;
    slc_lcd_ctrl #(.FRAME_ACC_LIMIT(64)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .ext_clk_in(ext_clk), .display_blank_n(blank_n), .backplane_drive(bp),
        .dual_out_27(d27), .dual_out_26(d26), .dual_out_25(d25), .seg_out(seg),
        .last_segment_out(s28), .shared_out(sh));
    slc_host_model host_u (.display_on(on), .display_blank_n(blank_n));
    initial forever #25 aclk = ~aclk;
    // External clock edges fall between the sampling edges
    initial forever #200 ext_clk = ~ext_clk;
    task automatic chk(input string nm, logic [33:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] a, logic [31:0] d, logic [1:0] r);
        bq.push_back(r);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, logic [31:0] d, logic [1:0] r);
        rq.push_back({r, d});
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic cfg(input logic [31:0] c);
        wr(ADDR_CTRL, c, RESP_OKAY);
        wr(ADDR_COMMIT, 32'h1, RESP_OKAY);
        repeat (4) @(posedge aclk);
    endtask : cfg
    // Lit segment is the inverse of the common phase
    task automatic pins(input logic [27:0] d, logic e28, blk);
        @(negedge aclk);
        chk("seg", 34'(seg), 34'({20{bp}} ^ (d[23:4] & {20{~blk}})));
        chk("dual", 34'({d27, d26, d25}), 34'({3{bp}} ^ (d[26:24] & {3{~blk}})));
        chk("s28", 34'(s28), 34'(e28 & (bp ^ (d[27] & ~blk))));
        @(posedge aclk);
    endtask : pins
    // Level changes of the common and of port 1 over n cycles
    task automatic rate(input int n, output int nb, np);
        logic pb, pp;
        nb = 0;
        np = 0;
        pb = bp;
        pp = sh[0];
        repeat (n) begin
            @(posedge aclk);
            nb += int'(bp != pb);
            np += int'(sh[0] != pp);
            pb = bp;
            pp = sh[0];
        end
    endtask : rate
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (bvalid && bready) chk("bresp", 34'(bresp), 34'(bq.pop_front()));
        if (rvalid && rready) chk("read", {rresp, rdata}, rq.pop_front());
        if (cyc == 60000) fails++;
        if (cyc == 60000) summarize();
    end
    initial begin
        dd = 28'($urandom(40457));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (20100) @(posedge aclk);
        rd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
        rd(8'h14, 32'h0, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
        wr(ADDR_DISP, 32'(dd), RESP_OKAY);
        cfg(CA & ~32'h20);
        on <= 1'b1;
        chk("inhibit", 34'({seg, sh, bp}), 34'h0);
        repeat (230) @(posedge aclk);
        pins(dd, 1'b0, 1'b0);
        chk("port", 34'(sh), 34'(dd[3:0]));
        wr(ADDR_DISP, 32'(~dd), RESP_OKAY);
        pins(dd, 1'b0, 1'b0);
        cfg(CA);
        pins(~dd, 1'b1, 1'b0);
        cfg(CA | 32'h100);
        pins(~dd, 1'b1, 1'b1);
        wr(ADDR_WIDTH, 32'h003f_321f, RESP_OKAY);
        cfg(CA | 32'h0003_9c00);
        repeat (16000) begin
            @(posedge aclk);
            foreach (cnt[i]) cnt[i] += int'(sh[i]);
        end
        foreach (cnt[i]) chk("pwm", 34'((cnt[i] + 125) / 250), 34'(pe[i]));
        // Rate code 2, port 1 as clock: 15000 steps per second, 6 in 400 us
        cfg(CA & ~32'h003c_0000 | 32'h0008_0800);
        rate(8000, tb, ts);
        chk("frame", 34'(tb), 34'(1375));
        chk("clock", 34'(ts), 34'(6));
        // External clock: 64 rising edges in 512 cycles give 11 phase changes
        cfg(CA & ~32'h003c_0000 | 32'h0008_0840);
        rate(512, tb, ts);
        chk("extclk", 34'(tb), 34'(11));
        cfg(CA | 32'h200);
        chk("lowpower", 34'({seg, bp, sh}), 34'({21'h0, ~dd[3:0]}));
        summarize();
    end
endmodule : testbench
